// >>> core/lsi_core.sv
// Limit outputs, PLC inputs, process data update and status LED.
// Assumes a classic Wishbone master on mclk and synchronous inputs.
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module lsi_core (
   input  wire logic                    mclk,
   input  wire logic                    nrst,
   input  wire logic                    opt_analog,
   input  wire logic [1:0]              plc_in,
   input  wire logic                    int_err,
   input  wire logic                    boot_done,
   input  wire logic [8*lsi_pkg::DW-1:0] amp_val,
   input  wire logic [7:0]              amp_present,
   input  wire logic [lsi_pkg::DW-1:0]  aux_val,
   input  wire logic                    aux_valid,
   output logic                         aux_ready,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic [31:0]                  wb_dat_o,
   output logic                         wb_ack_o,
   output logic [1:0]                   plc_out,
   output logic                         tare_pulse,
   output logic                         tare_clr_pulse,
   output logic                         led_green,
   output logic                         led_red
);

   typedef struct packed {
      logic [31:0]             ctrl;
      logic [31:0]             lo0;
      logic [31:0]             hi0;
      logic [31:0]             lo1;
      logic [31:0]             hi1;
      logic [1:0]              s1;
      logic [1:0]              s2;
      logic [1:0]              s3;
      logic [1:0]              lat;
      logic [1:0]              outq;
      logic                    tare;
      logic                    rtare;
      logic [31:0]             rdat;
      logic                    ack;
      logic [15:0]             upd;
      logic [4:0]              wp;
      logic [31:0]             cnt;
      // Two-entry buffer for auxiliary samples
      logic [1:0][31:0]        bd;
      logic [1:0]              bv;
      logic                    brp;
      logic                    bwp;
      logic                    rdy;
      lsi_pkg::lsi_state_t     st;
      logic [26:0]             ph;
      logic [26:0]             lamp;
      logic [3:0]              burst;
      logic                    bon;
      logic                    gap;
      logic                    grn;
      logic                    red;
   } lsi_st_t;

   lsi_st_t s_reg;
   lsi_st_t s_next;

   logic [31:0] ch_reg [lsi_pkg::NCH];
   logic [31:0] rec_reg [lsi_pkg::NREC];

   logic [31:0] aux_cur;
   logic [1:0]  rise;
   logic [1:0]  hit;
   logic        stopped;
   logic        fired;
   logic        slow_t;
   logic        fast_t;

   always_comb begin
      aux_cur = s_reg.bd[s_reg.brp];
      // Edge taken past the second stage, so a metastable first stage
      // never reaches the input functions
      rise    = s_reg.s2 & ~s_reg.s3;
      stopped = 1'b0;
      for (int i = 0; i < 2; i++) begin
         if (s_reg.ctrl[lsi_pkg::C_IFUN0 + 4*i +: 3] == lsi_pkg::IF_STOP
             && s_reg.s2[i])
            stopped = opt_analog;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_lim
         logic [2:0]  md;
         logic [31:0] lo;
         logic [31:0] hi;
         logic [31:0] v;
         assign md = s_reg.ctrl[lsi_pkg::C_OMODE0 + 4*g +: 3];
         assign lo = (g == 0) ? s_reg.lo0 : s_reg.lo1;
         assign hi = (g == 0) ? s_reg.hi0 : s_reg.hi1;
         assign v  = ch_reg[0];
         always_comb begin
            case (md)
               lsi_pkg::OM_DUN,
               lsi_pkg::OM_SUN: hit[g] = $signed(v) < $signed(lo);
               lsi_pkg::OM_DOV,
               lsi_pkg::OM_SOV: hit[g] = $signed(v) > $signed(hi);
               lsi_pkg::OM_WIN: hit[g] = $signed(v) >= $signed(lo)
                                      && $signed(v) <= $signed(hi);
               default:         hit[g] = 1'b0;
            endcase
         end
      end
   endgenerate

   always_comb begin
      s_next = s_reg;
      s_next.ack = 1'b0;
      s_next.tare = 1'b0;
      s_next.rtare = 1'b0;
      s_next.s1 = plc_in;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      fired = 1'b0;

      // Wishbone slave, one wait state
      if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
         s_next.ack = 1'b1;
         s_next.rdat = 32'h0;
         if (wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) begin
                  case (wb_adr_i)
                     lsi_pkg::A_CTRL: s_next.ctrl[8*b +: 8] = wb_dat_i[8*b +: 8];
                     lsi_pkg::A_LO0:  s_next.lo0[8*b +: 8]  = wb_dat_i[8*b +: 8];
                     lsi_pkg::A_HI0:  s_next.hi0[8*b +: 8]  = wb_dat_i[8*b +: 8];
                     lsi_pkg::A_LO1:  s_next.lo1[8*b +: 8]  = wb_dat_i[8*b +: 8];
                     lsi_pkg::A_HI1:  s_next.hi1[8*b +: 8]  = wb_dat_i[8*b +: 8];
                     default: ;
                  endcase
               end
            end
         end else begin
            case (wb_adr_i)
               lsi_pkg::A_CTRL: s_next.rdat = s_reg.ctrl;
               lsi_pkg::A_STAT: s_next.rdat = {24'h0, 1'b0, stopped, s_reg.st,
                                               s_reg.lat, s_reg.outq};
               lsi_pkg::A_LO0:  s_next.rdat = s_reg.lo0;
               lsi_pkg::A_HI0:  s_next.rdat = s_reg.hi0;
               lsi_pkg::A_LO1:  s_next.rdat = s_reg.lo1;
               lsi_pkg::A_HI1:  s_next.rdat = s_reg.hi1;
               lsi_pkg::A_CNT:  s_next.rdat = s_reg.cnt;
               default: begin
                  if (wb_adr_i >= lsi_pkg::A_CH
                      && wb_adr_i < lsi_pkg::A_CH + 8'(4*lsi_pkg::NCH))
                     s_next.rdat = ch_reg[4'((wb_adr_i - lsi_pkg::A_CH) >> 2)];
                  else if (wb_adr_i >= lsi_pkg::A_REC)
                     s_next.rdat = rec_reg[5'((wb_adr_i - lsi_pkg::A_REC) >> 2)];
               end
            endcase
         end
      end

      // Input functions on rising edge
      for (int i = 0; i < 2; i++) begin
         if (rise[i] && opt_analog) begin
            case (s_reg.ctrl[lsi_pkg::C_IFUN0 + 4*i +: 3])
               lsi_pkg::IF_TARE:  s_next.tare  = 1'b1;
               lsi_pkg::IF_RTARE: s_next.rtare = 1'b1;
               lsi_pkg::IF_RLIM1: s_next.lat[0] = 1'b0;
               lsi_pkg::IF_RLIM2: s_next.lat[1] = 1'b0;
               default: ;
            endcase
         end
      end

      for (int i = 0; i < 2; i++) begin
         case (s_reg.ctrl[lsi_pkg::C_OMODE0 + 4*i +: 3])
            lsi_pkg::OM_SUN, lsi_pkg::OM_SOV: begin
               if (hit[i])
                  s_next.lat[i] = 1'b1;
               s_next.outq[i] = s_next.lat[i];
            end
            default: begin
               s_next.lat[i] = 1'b0;
               s_next.outq[i] = hit[i];
            end
         endcase
         if (s_reg.ctrl[lsi_pkg::C_IFUN0 + 4*i +: 3] == lsi_pkg::IF_COPY)
            s_next.outq[i] = s_reg.s2[i];
         if (!opt_analog) begin
            s_next.outq[i] = 1'b0;
            s_next.lat[i] = 1'b0;
         end
      end

      // Auxiliary buffer write side
      if (aux_valid && !s_reg.bv[s_reg.bwp]) begin
         s_next.bd[s_reg.bwp] = aux_val;
         s_next.bv[s_reg.bwp] = 1'b1;
         s_next.bwp = ~s_reg.bwp;
      end

      // Update tick; counter keeps running, but no update fires when conversion stopped
      if (s_reg.upd == 16'(lsi_pkg::UPD_CYC - 1)) begin
         s_next.upd = 16'h0;
         fired = !stopped && s_reg.st == lsi_pkg::ST_RUN;
      end else begin
         s_next.upd = s_reg.upd + 16'h1;
      end
      if (fired) begin
         s_next.wp  = s_reg.wp + 5'h1;
         s_next.cnt = s_reg.cnt + 32'h1;
         if (s_reg.bv[s_reg.brp]) begin
            s_next.bv[s_reg.brp] = 1'b0;
            s_next.brp = ~s_reg.brp;
         end
      end

      // Ready registered from the next buffer state
      s_next.rdy = ~s_next.bv[s_next.bwp];

      // Status LED
      slow_t = s_reg.ph == 27'(lsi_pkg::SLOW_CYC - 1);
      s_next.ph = slow_t ? 27'h0 : s_reg.ph + 27'h1;
      fast_t = (s_reg.ph % 27'(lsi_pkg::FAST_CYC)) == 27'h0;
      if (slow_t)
         s_next.grn = ~s_reg.grn;
      case (s_reg.st)
         lsi_pkg::ST_LAMP: begin
            s_next.lamp = s_reg.lamp + 27'h1;
            if (fast_t) begin
               s_next.grn = ~s_reg.grn;
               s_next.red = ~s_reg.grn;
            end
            if (s_reg.lamp == 27'(lsi_pkg::LAMP_CYC - 1))
               s_next.st = lsi_pkg::ST_BOOT;
         end
         lsi_pkg::ST_BOOT: begin
            s_next.red = 1'b0;
            if (fast_t)
               s_next.grn = ~s_reg.grn;
            if (boot_done)
               s_next.st = lsi_pkg::ST_RUN;
         end
         lsi_pkg::ST_RUN: begin
            s_next.red = 1'b0;
            if (int_err) begin
               s_next.grn = 1'b0;
               if (fast_t)
                  s_next.red = ~s_reg.red;
               else
                  s_next.red = s_reg.red;
            end else if (s_reg.ctrl[lsi_pkg::C_FAULT]) begin
               s_next.grn = 1'b0;
               s_next.red = s_reg.red;
               if (s_reg.gap) begin
                  s_next.red = 1'b0;
                  s_next.lamp = s_reg.lamp + 27'h1;
                  if (s_reg.lamp == 27'(lsi_pkg::GAP_CYC - 1)) begin
                     s_next.gap = 1'b0;
                     s_next.lamp = 27'h0;
                     s_next.burst = 4'h0;
                  end
               end else if (fast_t) begin
                  s_next.red = ~s_reg.red;
                  if (s_reg.red) begin
                     s_next.burst = s_reg.burst + 4'h1;
                     if (s_reg.burst + 4'h1
                         >= s_reg.ctrl[lsi_pkg::C_ERRCODE +: 4]) begin
                        s_next.gap = 1'b1;
                        s_next.lamp = 27'h0;
                     end
                  end
               end
            end else if (stopped) begin
               s_next.red = fast_t ? ~s_reg.red : s_reg.red;
            end else if (s_reg.ctrl[lsi_pkg::C_OVL]) begin
               s_next.red = s_next.grn;
            end
         end
         default: s_next.st = lsi_pkg::ST_LAMP;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_reg     <= '0;
         // Buffer starts empty, so ready
         s_reg.rdy <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Live channels and record array
   // Live channels clear on reset, so limits see zero until the first
   // update; record slots need no reset as they fill in order
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         for (int k = 0; k < lsi_pkg::NCH; k++)
            ch_reg[k] <= 32'h0;
      end else if (fired) begin
         ch_reg[0] <= s_reg.bv[s_reg.brp] ? aux_cur : ch_reg[0];
         for (int k = 0; k < 8; k++)
            ch_reg[k+1] <= amp_present[k] ? amp_val[32*k +: 32] : 32'h0;
         rec_reg[s_reg.wp] <= s_reg.bv[s_reg.brp] ? aux_cur : ch_reg[0];
      end
   end

   always_comb begin
      aux_ready      = s_reg.rdy;
      wb_dat_o       = s_reg.rdat;
      wb_ack_o       = s_reg.ack;
      plc_out        = s_reg.outq;
      tare_pulse     = s_reg.tare;
      tare_clr_pulse = s_reg.rtare;
      led_green      = s_reg.grn;
      led_red        = s_reg.red;
   end

endmodule // lsi_core

// >>> inc/lsi_pkg.sv
// Package for the limit outputs and status indicator block.
// Assumes a 50 MHz system clock; all counts derive from it.
package lsi_pkg;

   localparam int unsigned CLK_HZ       = 50000000;
   localparam int unsigned UPD_HZ       = 3600;
   localparam int unsigned UPD_CYC      = CLK_HZ / UPD_HZ;
   localparam int unsigned SLOW_MS      = 500;
   localparam int unsigned FAST_MS      = 100;
   localparam int unsigned GAP_MS       = 1000;
   localparam int unsigned LAMP_MS      = 2000;
   localparam int unsigned SLOW_CYC     = CLK_HZ / 1000 * SLOW_MS;
   localparam int unsigned FAST_CYC     = CLK_HZ / 1000 * FAST_MS;
   localparam int unsigned GAP_CYC      = CLK_HZ / 1000 * GAP_MS;
   localparam int unsigned LAMP_CYC     = CLK_HZ / 1000 * LAMP_MS;

   localparam int unsigned NCH          = 9;
   localparam int unsigned NREC         = 32;
   localparam int unsigned DW           = 32;

   // Register word offsets (byte addresses)
   localparam logic [7:0] A_CTRL        = 8'h00;
   localparam logic [7:0] A_STAT        = 8'h04;
   localparam logic [7:0] A_LO0         = 8'h08;
   localparam logic [7:0] A_HI0         = 8'h0c;
   localparam logic [7:0] A_LO1         = 8'h10;
   localparam logic [7:0] A_HI1         = 8'h14;
   localparam logic [7:0] A_CNT         = 8'h18;
   localparam logic [7:0] A_CH          = 8'h40;
   localparam logic [7:0] A_REC         = 8'h80;

   // Control register fields
   localparam int unsigned C_OMODE0     = 0;
   localparam int unsigned C_OMODE1     = 4;
   localparam int unsigned C_IFUN0      = 8;
   localparam int unsigned C_IFUN1      = 12;
   localparam int unsigned C_ERRCODE    = 16;
   localparam int unsigned C_FAULT      = 20;
   localparam int unsigned C_OVL        = 21;

   typedef enum logic [2:0] {
      OM_OFF   = 3'h0,
      OM_DUN   = 3'h1,
      OM_DOV   = 3'h2,
      OM_SUN   = 3'h3,
      OM_SOV   = 3'h4,
      OM_WIN   = 3'h5
   } lsi_omode_t;

   typedef enum logic [2:0] {
      IF_NONE  = 3'h0,
      IF_TARE  = 3'h1,
      IF_RTARE = 3'h2,
      IF_RLIM1 = 3'h3,
      IF_RLIM2 = 3'h4,
      IF_COPY  = 3'h5,
      IF_STOP  = 3'h6
   } lsi_ifun_t;

   typedef enum logic [1:0] {
      ST_LAMP  = 2'h0,
      ST_BOOT  = 2'h1,
      ST_RUN   = 2'h2
   } lsi_state_t;

endpackage

// >>> tb/lsi_core_sva.sv
// Port checker for the limit and status core.
// Assumes every port is sampled on mclk; nrst low resets.
`timescale 1ns/10ps
module lsi_core_sva (
   input wire logic       mclk,
   input wire logic       nrst,
   input wire logic       opt_analog,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic [1:0] plc_out,
   input wire logic       tare_pulse,
   input wire logic       tare_clr_pulse
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_opt_off;
      !opt_analog [*3];
   endsequence
   a_ack_after_req: assert property (s_req |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_no_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_opt_off_out: assert property (s_opt_off |-> plc_out == 2'h0)
      else $error("output driven without option");
   a_opt_off_pulse: assert property (s_opt_off |-> !tare_pulse)
      else $error("tare without option");
   a_pulse_needs_opt: assert property (tare_clr_pulse |-> $past(opt_analog))
      else $error("tare clear without option");
   a_tare_single: assert property (tare_pulse |=> !tare_pulse)
      else $error("tare pulse too long");
   a_clr_single: assert property (tare_clr_pulse |=> !tare_clr_pulse)
      else $error("tare clear pulse too long");
endmodule // lsi_core_sva

bind lsi_core lsi_core_sva u_sva (
   .mclk(mclk), .nrst(nrst), .opt_analog(opt_analog),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .plc_out(plc_out), .tare_pulse(tare_pulse),
   .tare_clr_pulse(tare_clr_pulse)
);

// >>> tb/lsi_plc_model.sv
// PLC side model: drives the two discrete inputs.
// Assumes the caller steps it from the testbench on mclk.
`timescale 1ns/10ps
module lsi_plc_model (
   input wire logic       mclk,
   input wire logic [1:0] plc_out,
   output logic     [1:0] plc_in
);
   initial plc_in = 2'h0;
   // Level held for whole cycles, changed just after an edge
   task automatic drive(input int idx, input logic lvl, input int hold);
      @(posedge mclk);
      plc_in[idx] <= lvl;
      repeat (hold) @(posedge mclk);
   endtask
endmodule // lsi_plc_model

// >>> tb/tb_lsi_core.sv
// Self-checking bench for the limit and status core.
// Assumes the core, its package, checker and PLC model are compiled.
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   fail_count++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_lsi_core;
   logic         mclk = 1'b0;
   logic         nrst, opt_analog, int_err, boot_done, aux_valid;
   logic [1:0]   plc_in, plc_out;
   logic [255:0] amp_val;
   logic [7:0]   amp_present, wb_adr_i;
   logic [31:0]  aux_val, wb_dat_i, wb_dat_o, rd, val;
   logic [3:0]   wb_sel_i;
   logic         aux_ready, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic         tare_pulse, tare_clr_pulse, led_green, led_red;
   int           fail_count, samples_checked, seed, n_tare, n_clr, i, n;
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      if (tare_pulse === 1'b1) n_tare++;
      if (tare_clr_pulse === 1'b1) n_clr++;
   end
   lsi_core dut (.mclk(mclk), .nrst(nrst), .opt_analog(opt_analog),
      .plc_in(plc_in), .int_err(int_err), .boot_done(boot_done),
      .amp_val(amp_val), .amp_present(amp_present), .aux_val(aux_val),
      .aux_valid(aux_valid), .aux_ready(aux_ready), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .plc_out(plc_out), .tare_pulse(tare_pulse),
      .tare_clr_pulse(tare_clr_pulse), .led_green(led_green),
      .led_red(led_red));
   lsi_plc_model plc (.mclk(mclk), .plc_out(plc_out), .plc_in(plc_in));
   function automatic logic [31:0] ctrl_word(input logic [2:0] m0, m1,
                                             f0, f1);
      return (32'(m0) << lsi_pkg::C_OMODE0) | (32'(m1) << lsi_pkg::C_OMODE1)
         | (32'(f0) << lsi_pkg::C_IFUN0) | (32'(f1) << lsi_pkg::C_IFUN1);
   endfunction
   task automatic close_out;
      $display("mismatches %0d of %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge mclk);
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
      wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= s;
      for (k = 0; k < 20; k++) begin
         @(posedge mclk);
         if (wb_ack_o === 1'b1) break;
      end
      if (k == 20) begin fail_count++; close_out; end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      fail_count++;
      close_out;
   end
   initial begin
      seed = 28; nrst = 1'b0; opt_analog = 1'b1; int_err = 1'b0;
      boot_done = 1'b1; amp_present = 8'hff; aux_val = 32'h0;
      aux_valid = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
      wb_adr_i = 8'h0; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
      for (i = 0; i < 8; i++) amp_val[32*i +: 32] = $random(seed);
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      @(negedge mclk);
      `CHK(aux_ready, 1'b1)
      `CHK({led_green, led_red}, 2'h0)
      for (i = 0; i < 4; i++) begin
         val = $random(seed);
         wb(1'b1, lsi_pkg::A_LO0 + 8'(4 * i), val, 4'hf);
         wb(1'b0, lsi_pkg::A_LO0 + 8'(4 * i), 32'h0, 4'hf);
         `CHK(rd, val)
      end
      // One byte lane only
      wb(1'b1, lsi_pkg::A_LO0, 32'h0, 4'hf);
      wb(1'b1, lsi_pkg::A_LO0, 32'hffffffff, 4'h2);
      wb(1'b0, lsi_pkg::A_LO0, 32'h0, 4'hf);
      `CHK(rd, 32'h0000ff00)
      for (i = 0; i < 7; i++) begin
         val = ctrl_word(3'(i % 6), 3'(5 - i % 6), 3'(i), 3'(6 - i));
         wb(1'b1, lsi_pkg::A_CTRL, val, 4'hf);
         wb(1'b0, lsi_pkg::A_CTRL, 32'h0, 4'hf);
         `CHK(rd, val)
      end
      wb(1'b0, 8'h3c, 32'h0, 4'hf);
      `CHK(rd, 32'h0)
      wb(1'b0, lsi_pkg::A_CNT, 32'h0, 4'hf);
      `CHK(rd, 32'h0)
      wb(1'b1, lsi_pkg::A_CTRL, ctrl_word(lsi_pkg::OM_DOV, lsi_pkg::OM_DUN,
         lsi_pkg::IF_COPY, lsi_pkg::IF_COPY), 4'hf);
      for (i = 0; i < 4; i++) begin
         plc.drive(0, i[0], 0);
         plc.drive(1, i[1], 6);
         @(negedge mclk);
         `CHK(plc_out, 2'(i))
      end
      @(posedge mclk);
      opt_analog <= 1'b0;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      `CHK(plc_out, 2'h0)
      wb(1'b1, lsi_pkg::A_CTRL, ctrl_word(lsi_pkg::OM_OFF, lsi_pkg::OM_OFF,
         lsi_pkg::IF_TARE, lsi_pkg::IF_RTARE), 4'hf);
      for (n = 0; n < 2; n++) begin
         plc.drive(0, 1'b0, 0);
         plc.drive(1, 1'b0, 4);
         opt_analog <= n[0];
         repeat (4) @(posedge mclk);
         n_tare = 0;
         n_clr = 0;
         plc.drive(0, 1'b1, 0);
         plc.drive(1, 1'b1, 12);
         `CHK(n_tare, n)
         `CHK(n_clr, n)
      end
      // Channel zero reads zero until the first update
      wb(1'b1, lsi_pkg::A_LO0, 32'h1, 4'hf);
      wb(1'b1, lsi_pkg::A_HI0, 32'hffffffff, 4'hf);
      wb(1'b1, lsi_pkg::A_LO1, 32'hffffffff, 4'hf);
      wb(1'b1, lsi_pkg::A_HI1, 32'h1, 4'hf);
      wb(1'b1, lsi_pkg::A_CTRL, ctrl_word(lsi_pkg::OM_DUN, lsi_pkg::OM_WIN,
         lsi_pkg::IF_RLIM1, lsi_pkg::IF_NONE), 4'hf);
      @(negedge mclk);
      `CHK(plc_out, 2'h3)
      wb(1'b1, lsi_pkg::A_LO0, 32'hffffffff, 4'hf);
      wb(1'b1, lsi_pkg::A_LO1, 32'h1, 4'hf);
      @(negedge mclk);
      `CHK(plc_out, 2'h0)
      wb(1'b1, lsi_pkg::A_CTRL, ctrl_word(lsi_pkg::OM_SOV, lsi_pkg::OM_WIN,
         lsi_pkg::IF_RLIM1, lsi_pkg::IF_NONE), 4'hf);
      wb(1'b1, lsi_pkg::A_HI0, 32'h1, 4'hf);
      @(negedge mclk);
      `CHK(plc_out, 2'h1)
      plc.drive(0, 1'b0, 3);
      plc.drive(0, 1'b1, 6);
      @(negedge mclk);
      `CHK(plc_out, 2'h0)
      wb(1'b1, lsi_pkg::A_CTRL, ctrl_word(lsi_pkg::OM_OFF, lsi_pkg::OM_OFF,
         lsi_pkg::IF_NONE, lsi_pkg::IF_STOP), 4'hf);
      wb(1'b0, lsi_pkg::A_STAT, 32'h0, 4'hf);
      `CHK(rd, 32'h40)
      @(posedge mclk);
      aux_val <= $random(seed);
      aux_valid <= 1'b1;
      n = 0;
      for (i = 0; i < 10; i++) begin
         @(negedge mclk);
         if (aux_ready === 1'b1) n++;
      end
      `CHK(n, 2)
      `CHK(aux_ready, 1'b0)
      `CHK({led_green, led_red}, 2'h3)
      close_out;
   end
endmodule // tb_lsi_core
